//--- test_vgr_general_regs.sv
`timescale 1ns/1ps
module test_vgr_general_regs
    import vgr_pkg::*;
;
    logic        clock, rst_n, ce, io_rd_hit, io_wr_hit, mem_rd, mem_rom_hit, mem_ack;
    logic        crtc_sel, vga_io_en, seq_rst_async_n, seq_rst_sync_n, seq_run;
    logic        vsync_raw, hsync_raw, vdisp_en, disp_active, dac_cmp_active;
    logic        vretrace_irq_pend, vsync_out, hsync_out, vram_cpu_access, page_select_odd;
    logic [7:0]  io_rdata, seq_mem_mode, gra_misc, rdv;
    logic [7:0]  attr_colour_plane_enable, attr_colour_outputs;
    vgr_io_req_t io_req;
    vgr_mode_t   mode;
    int          fail_count, checks, cycles;

    vgr_general_regs dut (.clock(clock), .rst_n(rst_n), .ce(ce), .io_req(io_req),
        .io_rdata(io_rdata), .io_rd_hit(io_rd_hit), .io_wr_hit(io_wr_hit),
        .mem_rd(mem_rd), .mem_rom_hit(mem_rom_hit), .mem_ack(mem_ack),
        .crtc_sel(crtc_sel), .vga_io_en(vga_io_en), .seq_rst_async_n(seq_rst_async_n),
        .seq_rst_sync_n(seq_rst_sync_n), .seq_run(seq_run), .seq_mem_mode(seq_mem_mode),
        .gra_misc(gra_misc), .attr_colour_plane_enable(attr_colour_plane_enable),
        .attr_colour_outputs(attr_colour_outputs), .vsync_raw(vsync_raw),
        .hsync_raw(hsync_raw), .vdisp_en(vdisp_en), .disp_active(disp_active),
        .dac_cmp_active(dac_cmp_active), .vretrace_irq_pend(vretrace_irq_pend),
        .vsync_out(vsync_out), .hsync_out(hsync_out), .vram_cpu_access(vram_cpu_access),
        .page_select_odd(page_select_odd), .mode(mode));

    vgr_host_model host (.clock(clock), .io_rdata(io_rdata), .io_req(io_req),
        .seq_rst_async_n(seq_rst_async_n), .seq_rst_sync_n(seq_rst_sync_n));

    always #2 clock = ~clock;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic t_misc();
        logic [7:0] v;
        for (int c = 0; c < 4; c++) begin
            v = {c[1:0], 2'h3, c[1:0], c[0], 1'b1};
            {gra_misc[1], seq_mem_mode[3]} = c[1:0];
            host.clk_change(v);
            host.rd(VGR_PORT_MISC_RD, rdv);
            chk(rdv, v & 8'hEF, "misc readback");
            chk({mode.vsync_neg, mode.hsync_neg, mode.odd_page, page_select_odd,
                 mode.clk_sel, vram_cpu_access, mode.mono_emul},
                {c[1:0], {2{c==0}}, c[1:0], c[0], 1'b0}, "misc fields");
        end
    endtask

    task automatic t_sync();
        host.clk_change(8'h03);
        host.wr(16'h03DA, 8'hFF);
        host.rd(VGR_PORT_FEAT_RD, rdv);
        chk(rdv, 8'h08, "feature readback");
        vsync_raw = 1'b0;
        vdisp_en = 1'b1;
        hsync_raw = 1'b1;
        repeat (2) @(negedge clock);
        chk({vsync_out, hsync_out}, 8'h03, "vsync ored");
        host.wr(16'h03DA, 8'h00);
        repeat (2) @(negedge clock);
        chk({vsync_out, hsync_out}, 8'h01, "vsync normal");
        host.clk_change(8'hC3);
        repeat (2) @(negedge clock);
        chk({vsync_out, hsync_out}, 8'h02, "sync polarity");
    endtask

    task automatic t_status();
        disp_active = 1'b0;
        vsync_raw = 1'b1;
        for (int c = 0; c < 4; c++) begin
            attr_colour_plane_enable = {2'h0, c[1:0], 4'h0};
            attr_colour_outputs = 8'hD8;
            host.rd(16'h03DA, rdv);
            chk(rdv, {2'h0, c[1:0], 4'h9}, "status one");
            attr_colour_outputs = 8'h27;
            host.rd(16'h03DA, rdv);
            chk(rdv, {2'h0, ~c[1:0], 4'h9}, "status one mux");
        end
        disp_active = 1'b1;
        vsync_raw = 1'b0;
        vretrace_irq_pend = 1'b1;
        host.rd(VGR_PORT_STAT0, rdv);
        chk(rdv, 8'h80, "status zero irq");
        vretrace_irq_pend = 1'b0;
        dac_cmp_active = 1'b1;
        host.rd(VGR_PORT_STAT0, rdv);
        chk(rdv, 8'h10, "status zero cmp");
        host.rd(16'h03BA, rdv);
        chk(rdv, 8'h00, "mono status off");
        host.wr(VGR_PORT_MISC_WR, 8'h02);
        host.rd(16'h03BA, rdv);
        chk(rdv, {2'h0, 2'h0, 4'h0}, "mono status");
        host.rd(16'h03DA, rdv);
        chk(rdv, 8'h00, "colour status off");
        host.rd(16'h03B4, rdv);
    endtask

    task automatic t_mode();
        host.wr(16'h03B8, 8'hFF);
        ce = 1'b0;
        host.wr(16'h03B8, 8'h00);
        ce = 1'b1;
        host.rd(16'h03B8, rdv);
        chk(rdv, 8'hBF, "mode readback");
        chk({mode.mono_page1, mode.blank_screen, mode.video_en, mode.graphics},
            8'h0F, "mono mode bits");
        host.wr(VGR_PORT_MISC_WR, 8'h03);
        host.wr(16'h03D8, 8'h15);
        host.rd(16'h03D8, rdv);
        chk(rdv, 8'h15, "colour mode readback");
        chk({mode.bg_intensity, mode.hires_bw, mode.video_en, mode.bw_mode,
             mode.graphics, mode.wide_text}, 8'h15, "colour mode bits");
    endtask

    task automatic t_sleep();
        host.wr(VGR_PORT_SLEEP, 8'h00);
        host.rd(VGR_PORT_BOARD, rdv);
        chk(rdv, 8'h01, "sleep write gated");
        host.wr(VGR_PORT_ADDON, 8'h18);
        host.wr(VGR_PORT_SLEEP, 8'hFE);
        mem_rd = 1'b1;
        mem_rom_hit = 1'b1;
        #1;
        chk({vga_io_en, seq_run, mem_ack}, 8'h01, "asleep");
        host.wr(VGR_PORT_MISC_WR, 8'h00);
        host.rd(VGR_PORT_MISC_RD, rdv);
        chk(rdv, 8'h00, "read suspended");
        host.wr(VGR_PORT_SLEEP, 8'h01);
        host.rd(VGR_PORT_MISC_RD, rdv);
        chk(rdv, 8'h03, "write refused");
        host.rd(VGR_PORT_BOARD, rdv);
        chk(rdv, 8'h01, "board readback");
        host.wr(VGR_PORT_ADDON, 8'h10);
        chk({mem_ack, vga_io_en}, 8'h02, "addon off");
        host.wr(VGR_PORT_ADDON, 8'h18);
        mem_rd = 1'b0;
        #1;
        chk({mem_ack, vga_io_en}, 8'h01, "addon on");
    endtask

    task automatic final_report();
        if (fail_count == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fail_count++;
            final_report();
        end
    end

    initial begin
        {clock, rst_n, mem_rd, mem_rom_hit, vsync_raw, hsync_raw, vdisp_en} = '0;
        {disp_active, dac_cmp_active, vretrace_irq_pend} = '0;
        {seq_mem_mode, gra_misc, attr_colour_plane_enable, attr_colour_outputs} = '0;
        ce = 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
        rst_n = 1'b1;
        host.rd(VGR_PORT_MISC_RD, rdv);
        chk(rdv, 8'h00, "misc reset");
        host.rd(VGR_PORT_BOARD, rdv);
        chk(rdv, 8'h01, "board reset");
        t_misc();
        t_sync();
        t_status();
        t_mode();
        t_sleep();
        final_report();
    end
endmodule

//--- vgr_general_regs.sv
`timescale 1ns/1ps
// general control and status registers
module vgr_general_regs
    import vgr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire vgr_io_req_t io_req,
    output logic      [7:0]  io_rdata,
    output logic             io_rd_hit,
    output logic             io_wr_hit,
    input  wire logic        mem_rd,
    input  wire logic        mem_rom_hit,
    output logic             mem_ack,
    output logic             crtc_sel,
    output logic             vga_io_en,
    input  wire logic        seq_rst_async_n,
    input  wire logic        seq_rst_sync_n,
    output logic             seq_run,
    input  wire logic [7:0]  seq_mem_mode,
    input  wire logic [7:0]  gra_misc,
    input  wire logic [7:0]  attr_colour_plane_enable,
    input  wire logic [7:0]  attr_colour_outputs,
    input  wire logic        vsync_raw,
    input  wire logic        hsync_raw,
    input  wire logic        vdisp_en,
    input  wire logic        disp_active,
    input  wire logic        dac_cmp_active,
    input  wire logic        vretrace_irq_pend,
    output logic             vsync_out,
    output logic             hsync_out,
    output logic             vram_cpu_access,
    output logic             page_select_odd,
    output vgr_mode_t        mode
);
    //------------------------------------------------------------------
    // register outputs and strobes
    //------------------------------------------------------------------
    logic [7:0] misc_output;
    logic [7:0] feature_control;
    logic [7:0] addon_subsystem_enable;
    logic [7:0] subsystem_sleep;
    logic [7:0] legacy_mode_control;
    logic [7:0] input_status_zero;
    logic [7:0] input_status_one;
    logic [7:0] board_enable_readback;
    logic [1:0] diag_bits;
    logic [15:0] emul_base;
    logic       dec_en;
    logic       addon_hit;
    logic       sleep_hit_wr;
    logic       misc_hit_wr;
    logic       misc_hit_rd;
    logic       stat0_hit_rd;
    logic       board_hit_rd;
    logic       feat_hit_rd;
    logic       feat_hit_wr;
    logic       mode_hit;
    logic       stat1_hit_rd;
    logic       crtc_hit;
    logic       misc_we;
    logic       feat_we;
    logic       addon_we;
    logic       sleep_we;
    logic       mode_we;
    logic       odd_even_overr;
    logic [7:0] rdata_nxt;
    logic [7:0] rdata_r;
    logic       vsync_nxt;
    logic       vsync_r;
    logic       hsync_r;

    //------------------------------------------------------------------
    // address decoding
    //------------------------------------------------------------------
    // emulation range base, mono 3Bx or colour 3Dx
    assign emul_base = misc_output[VGR_MISC_ADDR_SEL]
                     ? VGR_PORT_COLR_BASE : VGR_PORT_MONO_BASE;
    // decoding alive only when add-on and sleep enables both set
    assign dec_en = addon_subsystem_enable[VGR_ADDON_EN]
                  & subsystem_sleep[VGR_SLEEP_EN];
    assign vga_io_en = dec_en;

    // add-on port always reachable for writes
    assign addon_hit    = io_req.wr & (io_req.addr == VGR_PORT_ADDON);
    // sleep port write survives suspension
    assign sleep_hit_wr = io_req.wr & (io_req.addr == VGR_PORT_SLEEP);
    assign misc_hit_wr  = dec_en & io_req.wr & (io_req.addr == VGR_PORT_MISC_WR);
    assign misc_hit_rd  = dec_en & io_req.rd & (io_req.addr == VGR_PORT_MISC_RD);
    assign stat0_hit_rd = dec_en & io_req.rd & (io_req.addr == VGR_PORT_STAT0);
    assign board_hit_rd = dec_en & io_req.rd & (io_req.addr == VGR_PORT_BOARD);
    assign feat_hit_rd  = dec_en & io_req.rd & (io_req.addr == VGR_PORT_FEAT_RD);
    assign feat_hit_wr  = dec_en & io_req.wr
                        & (io_req.addr == (emul_base | {12'h000, VGR_LOW_STAT1}));
    assign stat1_hit_rd = dec_en & io_req.rd
                        & (io_req.addr == (emul_base | {12'h000, VGR_LOW_STAT1}));
    assign mode_hit     = dec_en & (io_req.rd | io_req.wr)
                        & (io_req.addr == (emul_base | {12'h000, VGR_LOW_MODE}));
    assign crtc_hit     = dec_en & (io_req.rd | io_req.wr)
                        & ((io_req.addr == (emul_base | {12'h000, VGR_LOW_CRTC_IDX}))
                        |  (io_req.addr == (emul_base | {12'h000, VGR_LOW_CRTC_DAT})));
    assign crtc_sel     = crtc_hit;

    //------------------------------------------------------------------
    // write strobes
    //------------------------------------------------------------------
    assign misc_we  = misc_hit_wr;
    assign feat_we  = feat_hit_wr;
    assign addon_we = addon_hit;
    // sleep write needs add-on bit 4
    assign sleep_we = sleep_hit_wr & addon_subsystem_enable[VGR_ADDON_SLP_WE];
    assign mode_we  = mode_hit & io_req.wr;

    //------------------------------------------------------------------
    // register instances
    //------------------------------------------------------------------
    vgr_reg8 #(.MASK(VGR_MISC_MASK), .RESET(VGR_MISC_RST)) u_misc (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (misc_we),
        .wdata (io_req.wdata),
        .q     (misc_output)
    );

    vgr_reg8 #(.MASK(VGR_FEAT_MASK), .RESET(VGR_FEAT_RST)) u_feat (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (feat_we),
        .wdata (io_req.wdata),
        .q     (feature_control)
    );

    vgr_reg8 #(.MASK(VGR_ADDON_MASK), .RESET(VGR_ADDON_RST)) u_addon (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (addon_we),
        .wdata (io_req.wdata),
        .q     (addon_subsystem_enable)
    );

    vgr_reg8 #(.MASK(VGR_SLEEP_MASK), .RESET(VGR_SLEEP_RST)) u_sleep (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (sleep_we),
        .wdata (io_req.wdata),
        .q     (subsystem_sleep)
    );

    vgr_reg8 #(.MASK(VGR_MODE_MASK), .RESET(VGR_MODE_RST)) u_mode (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .we    (mode_we),
        .wdata (io_req.wdata),
        .q     (legacy_mode_control)
    );

    //------------------------------------------------------------------
    // status assembly
    //------------------------------------------------------------------
    vgr_status_mux u_diag (
        .colour (attr_colour_outputs),
        .sel    (attr_colour_plane_enable[5:4]),
        .diag   (diag_bits)
    );

    assign input_status_zero = {vretrace_irq_pend, 2'b00,
                                dac_cmp_active, 4'h0};
    assign input_status_one  = {2'b00, diag_bits,
                                vsync_raw,
                                2'b00, ~disp_active};
    assign board_enable_readback = {7'h00, subsystem_sleep[VGR_SLEEP_EN]};

    //------------------------------------------------------------------
    // read data select
    //------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (misc_hit_rd) begin
            rdata_nxt = misc_output;
        end else if (stat0_hit_rd) begin
            rdata_nxt = input_status_zero;
        end else if (board_hit_rd) begin
            rdata_nxt = board_enable_readback;
        end else if (feat_hit_rd) begin
            rdata_nxt = feature_control;
        end else if (stat1_hit_rd) begin
            rdata_nxt = input_status_one;
        end else if (mode_hit & io_req.rd) begin
            rdata_nxt = legacy_mode_control;
        end
    end

    assign io_rd_hit = misc_hit_rd | stat0_hit_rd | board_hit_rd | feat_hit_rd
                     | stat1_hit_rd | (mode_hit & io_req.rd);
    assign io_wr_hit = misc_we | feat_we | addon_we | sleep_hit_wr | mode_we;
    assign io_rdata  = rdata_r;

    // rom reads answered even while suspended
    assign mem_ack = mem_rd & mem_rom_hit;

    //------------------------------------------------------------------
    // sync shaping
    //------------------------------------------------------------------
    assign vsync_nxt = (feature_control[VGR_FEAT_VSYNC] ? (vsync_raw | vdisp_en)
                                                        : vsync_raw)
                     ^ misc_output[VGR_MISC_VPOL];

    // sequencer halts if either reset bit clear
    assign seq_run = seq_rst_async_n & seq_rst_sync_n & dec_en;

    //------------------------------------------------------------------
    // read and sync flops
    //------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
            vsync_r <= 1'b0;
            hsync_r <= 1'b0;
        end else if (ce) begin
            rdata_r <= rdata_nxt;
            vsync_r <= seq_run & vsync_nxt;
            hsync_r <= seq_run & (hsync_raw ^ misc_output[VGR_MISC_HPOL]);
        end
    end

    assign vsync_out = vsync_r;
    assign hsync_out = hsync_r;

    //------------------------------------------------------------------
    // memory gating and page select
    //------------------------------------------------------------------
    assign vram_cpu_access = dec_en & misc_output[VGR_MISC_VRAM_EN];
    assign odd_even_overr  = gra_misc[VGR_GRA_CHAIN_BIT] | seq_mem_mode[VGR_SEQ_OE_BIT];
    // page bit only counts outside override
    assign page_select_odd = ~odd_even_overr & misc_output[VGR_MISC_PAGE];

    //------------------------------------------------------------------
    // decoded mode fields
    //------------------------------------------------------------------
    always_comb begin
        mode              = '0;
        mode.mono_emul    = ~misc_output[VGR_MISC_ADDR_SEL];
        mode.vram_cpu_en  = misc_output[VGR_MISC_VRAM_EN];
        mode.clk_sel      = vgr_clk_sel_t'(misc_output[VGR_MISC_CLK_LO +: 2]);
        mode.odd_page     = page_select_odd;
        mode.hsync_neg    = misc_output[VGR_MISC_HPOL];
        mode.vsync_neg    = misc_output[VGR_MISC_VPOL];
        mode.graphics     = legacy_mode_control[1];
        mode.video_en     = legacy_mode_control[3];
        if (misc_output[VGR_MISC_ADDR_SEL]) begin
            mode.wide_text    = legacy_mode_control[0];
            mode.bw_mode      = legacy_mode_control[2];
            mode.hires_bw     = legacy_mode_control[4];
            mode.bg_intensity = legacy_mode_control[5];
        end else begin
            mode.blank_screen = legacy_mode_control[5];
            mode.mono_page1   = legacy_mode_control[7];
        end
    end
endmodule

//--- vgr_general_regs_chk.sv
`timescale 1ns/1ps
// port-level checks for the general register bank
module vgr_general_regs_chk
    import vgr_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire vgr_io_req_t io_req,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rd_hit,
    input  wire logic        io_wr_hit,
    input  wire logic        mem_rd,
    input  wire logic        mem_rom_hit,
    input  wire logic        mem_ack,
    input  wire logic        crtc_sel,
    input  wire logic        vga_io_en,
    input  wire logic        seq_rst_async_n,
    input  wire logic        seq_rst_sync_n,
    input  wire logic        seq_run,
    input  wire logic [7:0]  seq_mem_mode,
    input  wire logic [7:0]  gra_misc,
    input  wire logic        hsync_raw,
    input  wire logic        dac_cmp_active,
    input  wire logic        vretrace_irq_pend,
    input  wire logic        vsync_out,
    input  wire logic        hsync_out,
    input  wire logic        vram_cpu_access,
    input  wire logic        page_select_odd,
    input  wire vgr_mode_t   mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // rom reads answered even when asleep
    property p_rom_ack;
        mem_ack == (mem_rd && mem_rom_hit);
    endproperty
    a_rom_ack: assert property (p_rom_ack)
        else $error("rom read not answered");

    // either reset bit low halts the sequencer
    property p_seq_halt;
        !(seq_rst_async_n && seq_rst_sync_n) |-> !seq_run;
    endproperty
    a_seq_halt: assert property (p_seq_halt)
        else $error("sequencer runs while reset");

    property p_sync_off;
        ce && !seq_run |=> !vsync_out && !hsync_out;
    endproperty
    a_sync_off: assert property (p_sync_off)
        else $error("sync active while halted");

    property p_hpol;
        ce && seq_run |=> hsync_out == ($past(hsync_raw) ^ $past(mode.hsync_neg));
    endproperty
    a_hpol: assert property (p_hpol)
        else $error("hsync polarity wrong");

    property p_vram;
        vram_cpu_access == (vga_io_en && mode.vram_cpu_en);
    endproperty
    a_vram: assert property (p_vram)
        else $error("vram access while disabled");

    property p_crtc;
        crtc_sel == (vga_io_en && (io_req.rd || io_req.wr) && io_req.addr[3:1] == 3'h2
            && io_req.addr[15:4] == (mode.mono_emul ? 12'h03B : 12'h03D));
    endproperty
    a_crtc: assert property (p_crtc)
        else $error("crtc port outside range");

    property p_page;
        gra_misc[VGR_GRA_CHAIN_BIT] || seq_mem_mode[VGR_SEQ_OE_BIT] |-> !page_select_odd;
    endproperty
    a_page: assert property (p_page)
        else $error("page select wrong");

    property p_sleep_wr;
        io_req.wr && !vga_io_en && io_req.addr != VGR_PORT_SLEEP
            && io_req.addr != VGR_PORT_ADDON |-> !io_wr_hit;
    endproperty
    a_sleep_wr: assert property (p_sleep_wr)
        else $error("write accepted while suspended");

    property p_rd_off;
        ce && io_req.rd && !vga_io_en |-> !io_rd_hit ##1 io_rdata == 8'h00;
    endproperty
    a_rd_off: assert property (p_rd_off)
        else $error("read answered while suspended");

    property p_stat0;
        ce && io_req.rd && vga_io_en && io_req.addr == VGR_PORT_STAT0 |=>
            io_rdata == {$past(vretrace_irq_pend), 2'h0, $past(dac_cmp_active), 4'h0};
    endproperty
    a_stat0: assert property (p_stat0)
        else $error("status zero wrong");
endmodule

bind vgr_general_regs vgr_general_regs_chk u_chk (
    .clock, .rst_n, .ce, .io_req, .io_rdata, .io_rd_hit, .io_wr_hit, .mem_rd, .mem_rom_hit,
    .mem_ack, .crtc_sel, .vga_io_en, .seq_rst_async_n, .seq_rst_sync_n, .seq_run,
    .seq_mem_mode, .gra_misc, .hsync_raw, .dac_cmp_active, .vretrace_irq_pend,
    .vsync_out, .hsync_out, .vram_cpu_access, .page_select_odd, .mode
);

//--- vgr_host_model.sv
`timescale 1ns/1ps
// host cpu issuing single-cycle i/o port cycles
module vgr_host_model
    import vgr_pkg::*;
(
    input  wire logic       clock,
    input  wire logic [7:0] io_rdata,
    output vgr_io_req_t     io_req,
    output logic            seq_rst_async_n,
    output logic            seq_rst_sync_n
);
    initial begin
        io_req = '0;
        {seq_rst_async_n, seq_rst_sync_n} = 2'b11;
    end

    // released lines show inverted values, not stale ones
    task automatic wr(input logic [15:0] addr, input logic [7:0] data);
        @(negedge clock);
        io_req = '{rd: 1'b0, wr: 1'b1, addr: addr, wdata: data};
        @(negedge clock);
        io_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: ~data};
    endtask

    task automatic rd(input logic [15:0] addr, output logic [7:0] data);
        @(negedge clock);
        io_req = '{rd: 1'b1, wr: 1'b0, addr: addr, wdata: 8'h00};
        @(negedge clock);
        data = io_rdata;
        io_req = '{rd: 1'b0, wr: 1'b0, addr: ~addr, wdata: 8'hFF};
    endtask

    // clock select changes only with the sequencer halted
    task automatic clk_change(input logic [7:0] misc);
        @(negedge clock);
        {seq_rst_async_n, seq_rst_sync_n} = 2'b00;
        wr(VGR_PORT_MISC_WR, misc);
        {seq_rst_async_n, seq_rst_sync_n} = 2'b11;
    endtask
endmodule

//--- vgr_pkg.sv
//----------------------------------------------------------------------
// vga general control register package
//----------------------------------------------------------------------
// Overview of operation
// - CRTC/status one/mode ports follow address select bit
// - misc output written 3C2h, read back 3CCh
// - misc bit 1 gates CPU video memory access
// - misc bits 3:2 select pixel clock
// - misc bit 5 picks odd/even page
// - misc bits 7:6 set sync polarities
// - feature bit 3 ORs vsync with display enable
// - status zero bit 4 shows comparator
// - status zero bit 7 shows retrace interrupt
// - status one bit 0 shows blanking
// - status one bit 3 shows vertical retrace
// - status one bits 5:4 mux colour outputs
// - colour emulation mode control bit meanings
// - monochrome emulation mode control bit meanings
// - add-on bit 4 gates sleep register writes
// - sleep bit 0 low disables video subsystem
// - port 3C3h reads sleep enable bit
// - cleared sequencer reset bits halt sequencer
package vgr_pkg;

    //------------------------------------------------------------------
    // port addresses
    //------------------------------------------------------------------
    localparam logic [15:0] VGR_PORT_SLEEP     = 16'h0102;
    localparam logic [15:0] VGR_PORT_MISC_WR   = 16'h03C2;
    localparam logic [15:0] VGR_PORT_STAT0     = 16'h03C2;
    localparam logic [15:0] VGR_PORT_BOARD     = 16'h03C3;
    localparam logic [15:0] VGR_PORT_FEAT_RD   = 16'h03CA;
    localparam logic [15:0] VGR_PORT_MISC_RD   = 16'h03CC;
    localparam logic [15:0] VGR_PORT_ADDON     = 16'h46E8;
    localparam logic [15:0] VGR_PORT_MONO_BASE = 16'h03B0;
    localparam logic [15:0] VGR_PORT_COLR_BASE = 16'h03D0;
    localparam logic [3:0]  VGR_LOW_CRTC_IDX   = 4'h4;
    localparam logic [3:0]  VGR_LOW_CRTC_DAT   = 4'h5;
    localparam logic [3:0]  VGR_LOW_MODE       = 4'h8;
    localparam logic [3:0]  VGR_LOW_STAT1      = 4'hA;

    //------------------------------------------------------------------
    // field positions
    //------------------------------------------------------------------
    localparam int VGR_MISC_ADDR_SEL = 0;
    localparam int VGR_MISC_VRAM_EN  = 1;
    localparam int VGR_MISC_CLK_LO   = 2;
    localparam int VGR_MISC_PAGE     = 5;
    localparam int VGR_MISC_HPOL     = 6;
    localparam int VGR_MISC_VPOL     = 7;
    localparam int VGR_FEAT_VSYNC    = 3;
    localparam int VGR_ADDON_EN      = 3;
    localparam int VGR_ADDON_SLP_WE  = 4;
    localparam int VGR_SLEEP_EN      = 0;
    localparam int VGR_SEQ_OE_BIT    = 3;
    localparam int VGR_GRA_CHAIN_BIT = 1;

    //------------------------------------------------------------------
    // writable masks and reset values
    //------------------------------------------------------------------
    localparam logic [7:0] VGR_MISC_MASK   = 8'hEF;
    localparam logic [7:0] VGR_FEAT_MASK   = 8'h08;
    localparam logic [7:0] VGR_ADDON_MASK  = 8'h18;
    localparam logic [7:0] VGR_SLEEP_MASK  = 8'h01;
    localparam logic [7:0] VGR_MODE_MASK   = 8'hBF;
    localparam logic [7:0] VGR_MISC_RST    = 8'h00;
    localparam logic [7:0] VGR_FEAT_RST    = 8'h00;
    localparam logic [7:0] VGR_ADDON_RST   = 8'h08;
    localparam logic [7:0] VGR_SLEEP_RST   = 8'h01;
    localparam logic [7:0] VGR_MODE_RST    = 8'h00;

    //------------------------------------------------------------------
    // types
    //------------------------------------------------------------------
    typedef enum logic [1:0] {
        VGR_CLK_25M,
        VGR_CLK_28M,
        VGR_CLK_RSV2,
        VGR_CLK_RSV3
    } vgr_clk_sel_t;

    // host i/o request
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } vgr_io_req_t;

    // decoded video mode controls
    typedef struct packed {
        logic         mono_emul;
        logic         vram_cpu_en;
        vgr_clk_sel_t clk_sel;
        logic         odd_page;
        logic         hsync_neg;
        logic         vsync_neg;
        logic         wide_text;
        logic         graphics;
        logic         bw_mode;
        logic         video_en;
        logic         hires_bw;
        logic         bg_intensity;
        logic         blank_screen;
        logic         mono_page1;
    } vgr_mode_t;

endpackage

//--- vgr_reg8.sv
`timescale 1ns/1ps
// masked byte register with write strobe
module vgr_reg8
    import vgr_pkg::*;
#(
    parameter logic [7:0] MASK  = 8'hFF,
    parameter logic [7:0] RESET = 8'h00
) (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       we,
    input  wire logic [7:0] wdata,
    output logic      [7:0] q
);
    //------------------------------------------------------------------
    // storage
    //------------------------------------------------------------------
    logic [7:0] q_r;
    logic [7:0] q_nxt;

    // reserved bits stay zero
    assign q_nxt = (we) ? (wdata & MASK) : q_r;
    assign q     = q_r;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= RESET & MASK;
        end else if (ce) begin
            q_r <= q_nxt;
        end
    end
endmodule

//--- vgr_status_mux.sv
`timescale 1ns/1ps
// diagnostic colour output selector
module vgr_status_mux
    import vgr_pkg::*;
(
    input  wire logic [7:0] colour,
    input  wire logic [1:0] sel,
    output logic      [1:0] diag
);
    //------------------------------------------------------------------
    // pick two of eight colour outputs
    //------------------------------------------------------------------
    always_comb begin
        unique case (sel)
            2'h0: diag = {colour[2], colour[0]};
            2'h1: diag = {colour[5], colour[4]};
            2'h2: diag = {colour[3], colour[1]};
            2'h3: diag = {colour[7], colour[6]};
        endcase
    end
endmodule
